/* ext_rst_model.sv */
// partner model: external reset circuit and the boot strap pins.
// assumes the bench calls its tasks; the clock is the core clock.
`default_nettype none
module ext_rst_model
(
  // clock
  input  wire logic i_clk,
  // pins seen by the device
  output logic      o_reset_n,
  output logic      o_boot_mode_select_pin,
  output logic      o_test_mode_select_pin,
  output logic      o_port_zero_bit_zero_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // pin has a pull-up, so it idles high; straps start in debug mode
  initial
  begin
    o_reset_n = 1'h1;
    {o_boot_mode_select_pin, o_test_mode_select_pin, o_port_zero_bit_zero_pin} = 3'h2;
  end

  // straps alone, reset pin left where it is; call just after a falling edge
  task automatic set_straps(input logic [2:0] straps);
    {o_boot_mode_select_pin, o_test_mode_select_pin, o_port_zero_bit_zero_pin} = straps;
  endtask

  // straps settle before the pin drops so they are valid when the sequence ends
  task automatic pin_reset(input int cyc, input logic [2:0] straps);
    @(negedge i_clk);
    set_straps(straps);
    o_reset_n = 1'h0;
    repeat (cyc) @(negedge i_clk);
    o_reset_n = 1'h1;
  endtask
endmodule // ext_rst_model
`default_nettype wire

/* reset_control_unit.sv */
// reset control unit: merges five reset sources, latches boot straps, drives regulators.
// assumes pins are asynchronous; watchdog, brownout, power-down requests come from core logic.
`default_nettype none
module reset_control_unit
  import rst_ctrl_pkg::*;
#(
  parameter int unsigned STRETCH = STRETCH_CYC
)
(
  // clock and power-on reset
  input  wire logic I_CORE_CLK,
  input  wire logic I_RST_N,
  // external pins
  input  wire logic I_EXT_RESET_N,
  input  wire logic I_BOOT_MODE_SELECT_PIN,
  input  wire logic I_TEST_MODE_SELECT_PIN,
  input  wire logic I_PORT_ZERO_BIT_ZERO_PIN,
  // on-chip requests
  input  wire logic I_WATCHDOG_UNIT_RST,
  input  wire logic I_BROWNOUT,
  input  wire logic I_WAKEUP,
  input  wire logic I_POWER_DOWN_REQ,
  // reset outputs
  output logic      O_SYS_RST_N,
  output logic      O_CLK_RST_N,
  output rst_src_type    O_CAUSE,
  output rst_effect_type O_EFFECT,
  output boot_mode_type  O_BOOT_MODE,
  // regulators
  output logic      O_MAIN_REG_EN,
  output logic      O_LP_REG_EN,
  output logic      O_POWER_DOWN
);
  typedef enum logic [1:0] {ST_RESET, ST_STRETCH, ST_RUN, ST_SLEEP} state_type;

  state_type   state;
  logic        pin_n;
  logic        pin_low;
  logic [3:0]  low_cnt;
  logic        hw_req;
  logic        any_req;
  rst_src_type pend;
  logic [$clog2(STRETCH+1)-1:0] str_cnt;
  logic [2:0]  boot_s1;
  logic [2:0]  boot_pins;

  // pin passes two flip-flops before use
  rst_sync u_pin_sync (.I_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .i_async(I_EXT_RESET_N),
                       .o_sync(pin_n));

  // pin reset qualified by 100 ns of low level
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      low_cnt <= 4'h0;
    else if (pin_n)
      low_cnt <= 4'h0;
    else if (low_cnt < 4'(HW_RST_MIN_CYC))
      low_cnt <= low_cnt + 4'h1;
  end
  assign pin_low = !pin_n;
  assign hw_req  = pin_low && (low_cnt >= 4'(HW_RST_MIN_CYC - 1));
  assign any_req = hw_req || I_WATCHDOG_UNIT_RST || I_BROWNOUT || (state == ST_SLEEP && I_WAKEUP);

  // sources collected while reset runs; power-on seeds the first record
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      pend <= '{power_on: 1'b1, default: 1'b0};
    else if (state == ST_RUN || state == ST_SLEEP)
    begin
      if (any_req)
        pend <= '{power_on: 1'b0, hardware: hw_req, watchdog: I_WATCHDOG_UNIT_RST,
                  wakeup: state == ST_SLEEP && I_WAKEUP, brownout: I_BROWNOUT};
    end
    else
    begin
      pend.hardware <= pend.hardware | hw_req;
      pend.watchdog <= pend.watchdog | I_WATCHDOG_UNIT_RST;
      pend.brownout <= pend.brownout | I_BROWNOUT;
    end
  end

  // sequencer: hold reset until the pin, watchdog and brownout requests have gone, then stretch
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state   <= ST_RESET;
      str_cnt <= '0;
    end
    else
    begin
      case (state)
        ST_RESET:
        begin
          str_cnt <= '0;
          if (!pin_low && !I_WATCHDOG_UNIT_RST && !I_BROWNOUT)
            state <= ST_STRETCH;
        end
        ST_STRETCH:
        begin
          if (pin_low || I_WATCHDOG_UNIT_RST || I_BROWNOUT)
            state <= ST_RESET;
          else if (str_cnt == ($bits(str_cnt))'(STRETCH - 1))
            state <= ST_RUN;
          else
            str_cnt <= str_cnt + ($bits(str_cnt))'(1);
        end
        ST_RUN:
          if (any_req)
            state <= ST_RESET;
          else if (I_POWER_DOWN_REQ)
            state <= ST_SLEEP;
        ST_SLEEP:
          if (any_req)
            state <= ST_RESET;
        default:
          state <= ST_RESET;
      endcase
    end
  end

  // outputs registered from the sequencer
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_SYS_RST_N <= 1'b0;
      O_CLK_RST_N <= 1'b0;
    end
    else
    begin
      O_SYS_RST_N <= (state == ST_RUN || state == ST_SLEEP) && !any_req;
      // watchdog-only reset leaves oscillator and pll running
      O_CLK_RST_N <= (state == ST_RUN || state == ST_SLEEP) ? !(any_req && !(I_WATCHDOG_UNIT_RST
                     && !hw_req && !I_BROWNOUT)) : (O_CLK_RST_N && pend.watchdog && !pend.hardware
                     && !pend.brownout && !pend.power_on);
    end
  end

  // cause and effect reported once the sequence ends
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_CAUSE  <= '0;
      O_EFFECT <= '{ram_unreliable: 1'b1, default: 1'b0};
    end
    else if (state == ST_STRETCH && str_cnt == ($bits(str_cnt))'(STRETCH - 1) && !any_req)
    begin
      O_CAUSE                 <= pend;
      O_EFFECT.ram_unreliable <= pend.power_on | pend.brownout;
      O_EFFECT.nmi_disable    <= pend.wakeup | pend.watchdog;
      O_EFFECT.clk_reset      <= !(pend.watchdog && !pend.hardware && !pend.power_on
                                   && !pend.brownout);
      O_EFFECT.boot_relatch   <= pend.power_on | pend.hardware;
    end
  end

  // boot straps sampled on the last stretch cycle of a power-on or pin reset only;
  // by then the strap synchroniser has left its reset value (needs a stretch of two or more)
  always_ff @(posedge I_CORE_CLK)
  begin
    if (state == ST_STRETCH && str_cnt == ($bits(str_cnt))'(STRETCH - 1)
        && (pend.power_on || pend.hardware))
      O_BOOT_MODE <= boot_decode(boot_pins);
  end

  // straps are asynchronous: two flops each
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      boot_s1   <= 3'h0;
      boot_pins <= 3'h0;
    end
    else
    begin
      boot_s1   <= {I_BOOT_MODE_SELECT_PIN, I_TEST_MODE_SELECT_PIN, I_PORT_ZERO_BIT_ZERO_PIN};
      boot_pins <= boot_s1;
    end
  end

  function automatic boot_mode_type boot_decode(input logic [2:0] p);
    case (p[2:1])
      2'h2:    boot_decode = BOOT_USER;
      2'h0:    boot_decode = BOOT_LOADER;
      2'h1:    boot_decode = BOOT_DEBUG;
      default: boot_decode = BOOT_JTAG;
    endcase
  endfunction

  // regulators: main off only while asleep, low-power always on
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_MAIN_REG_EN <= 1'b1;
      O_POWER_DOWN  <= 1'b0;
    end
    else
    begin
      O_MAIN_REG_EN <= !(state == ST_SLEEP && !any_req);
      O_POWER_DOWN  <= state == ST_SLEEP && !any_req;
    end
  end
  assign O_LP_REG_EN = 1'b1;

  property p_pin_reset;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      hw_req |=> !O_SYS_RST_N;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not applied");

  property p_wdt_reset;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (I_WATCHDOG_UNIT_RST && state == ST_RUN) |=> (state == ST_RESET && !O_SYS_RST_N);
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset ignored");

  property p_short_pulse;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (pin_n ##1 !pin_n) |-> !hw_req;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse accepted");

  property p_release;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (state == ST_STRETCH && (pin_low || I_WATCHDOG_UNIT_RST || I_BROWNOUT))
        |=> state == ST_RESET;
  endproperty
  a_release: assert property (p_release) else $error("released with source active");

  property p_sleep_reg;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (state == ST_SLEEP && !any_req) |=> !O_MAIN_REG_EN && O_POWER_DOWN;
  endproperty
  a_sleep_reg: assert property (p_sleep_reg) else $error("main regulator on in sleep");

  property p_run_reg;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (state == ST_RUN) |=> O_MAIN_REG_EN && O_LP_REG_EN;
  endproperty
  a_run_reg: assert property (p_run_reg) else $error("regulator off in run");

  property p_ram;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      $rose(O_SYS_RST_N) |-> O_EFFECT.ram_unreliable == (O_CAUSE.power_on | O_CAUSE.brownout);
  endproperty
  a_ram: assert property (p_ram) else $error("memory effect wrong");

  property p_boot_hold;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (O_SYS_RST_N && $past(O_SYS_RST_N)) |-> $stable(O_BOOT_MODE);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot mode changed");

  property p_nmi;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      $rose(O_SYS_RST_N) |-> O_EFFECT.nmi_disable == (O_CAUSE.wakeup | O_CAUSE.watchdog);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi effect wrong");
endmodule : reset_control_unit
`default_nettype wire

/* rst_ctrl_pkg.sv */
// package for the reset control unit: reset causes, boot choices, carriers, timing.
// assumes a single 25 MHz core clock.
`default_nettype none
package rst_ctrl_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned HW_RST_MIN_NS    = 100;
  // a legal low pulse always spans this many rising edges, whatever its phase,
  // so asking for more would let a valid pin reset slip through
  localparam int unsigned HW_RST_MIN_CYC   = HW_RST_MIN_NS / CLK_PERIOD_NS;
  localparam int unsigned STRETCH_CYC      = 16;
  localparam logic [1:0]  BOOT_RST_VAL     = 2'h0;

  // one bit per reset source
  typedef struct packed {
    logic power_on;
    logic hardware;
    logic watchdog;
    logic wakeup;
    logic brownout;
  } rst_src_type;

  typedef enum logic [1:0] {BOOT_USER, BOOT_LOADER, BOOT_DEBUG, BOOT_JTAG} boot_mode_type;

  // what the last reset did to the device
  typedef struct packed {
    logic ram_unreliable;
    logic nmi_disable;
    logic clk_reset;
    logic boot_relatch;
  } rst_effect_type;
endpackage : rst_ctrl_pkg
`default_nettype wire

/* rst_sync.sv */
// two-stage synchroniser for one asynchronous level.
// assumes the destination clock is the core clock.
`default_nettype none
module rst_sync
  import rst_ctrl_pkg::*;
(
  input  wire logic I_CLK,
  input  wire logic I_RST_N,
  input  wire logic i_async,
  output logic      o_sync
);
  logic stage1;

  // first stage feeds only the second stage
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      stage1 <= 1'b1;
      o_sync <= 1'b1;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : rst_sync
`default_nettype wire

/* tb_reset_control_unit.sv */
// testbench for the reset control unit with a short stretch count.
// assumes ext_rst_model drives the reset pin and the straps.
`default_nettype none
module tb_reset_control_unit;
  import rst_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk = 1'h0;
  logic           rst_n = 1'h0;
  logic           ext_n, boot_mode_select_pin, tsel, p00;
  logic           wdg = 1'h0, bout = 1'h0, wake = 1'h0, pd_req = 1'h0;
  logic           sys_n, clk_n, main_en, lp_en, pd;
  rst_src_type    cause;
  rst_effect_type eff;
  boot_mode_type  boot;
  int             n_fail = 0;
  int             cmp_count = 0;

  // 25 MHz core clock
  always #20 clk = ~clk;

  reset_control_unit #(.STRETCH(2)) i_reset_control_unit (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_EXT_RESET_N(ext_n),
    .I_BOOT_MODE_SELECT_PIN(boot_mode_select_pin), .I_TEST_MODE_SELECT_PIN(tsel),
    .I_PORT_ZERO_BIT_ZERO_PIN(p00), .I_WATCHDOG_UNIT_RST(wdg), .I_BROWNOUT(bout),
    .I_WAKEUP(wake), .I_POWER_DOWN_REQ(pd_req), .O_SYS_RST_N(sys_n), .O_CLK_RST_N(clk_n),
    .O_CAUSE(cause), .O_EFFECT(eff), .O_BOOT_MODE(boot), .O_MAIN_REG_EN(main_en),
    .O_LP_REG_EN(lp_en), .O_POWER_DOWN(pd));

  ext_rst_model i_ext_rst_model (
    .i_clk(clk), .o_reset_n(ext_n), .o_boot_mode_select_pin(boot_mode_select_pin),
    .o_test_mode_select_pin(tsel), .o_port_zero_bit_zero_pin(p00));

  // case equality so an unknown never matches
  task automatic chk(input logic [4:0] got, input logic [4:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // bounded wait for the internal reset to reach lvl
  task automatic wait_rst(input logic lvl);
    int i;
    for (i = 0; i < 100 && sys_n !== lvl; i++)
      @(negedge clk);
    if (sys_n !== lvl)
    begin
      n_fail++;
      $display("mismatch at %0t: internal reset wait timed out", $time);
      give_verdict();
    end
  endtask

  // also run as the last test, a second power-on reset
  task automatic t_power_on(input boot_mode_type exp);
    @(negedge clk);
    rst_n = 1'h0;
    repeat (10) @(negedge clk);
    chk(sys_n, 5'h0, "sys rst in por");
    chk(clk_n, 5'h0, "clk rst in por");
    rst_n = 1'h1;
    wait_rst(1'h1);
    chk(cause, 5'h10, "por cause");
    chk(eff.ram_unreliable, 5'h1, "por ram");
    chk(boot, exp, "por boot");
    chk(main_en, 5'h1, "main reg run");
    chk(lp_en, 5'h1, "lp reg run");
    $display("test power_on done");
  endtask

  // straps change first: a watchdog reset must not relatch them
  task automatic t_watchdog();
    @(negedge clk);
    i_ext_rst_model.set_straps(3'h4);
    wdg = 1'h1;
    @(negedge clk);
    chk(sys_n, 5'h0, "wdg asserts");
    chk(clk_n, 5'h1, "wdg keeps clk");
    wdg = 1'h0;
    wait_rst(1'h1);
    chk(cause, 5'h04, "wdg cause");
    chk(eff.ram_unreliable, 5'h0, "wdg ram");
    chk(eff.nmi_disable, 5'h1, "wdg nmi");
    chk(eff, 5'h04, "wdg effect");
    chk(boot, BOOT_DEBUG, "wdg boot");
    $display("test watchdog done");
  endtask

  task automatic t_brownout();
    @(negedge clk);
    bout = 1'h1;
    wait_rst(1'h0);
    chk(clk_n, 5'h0, "bout stops clk");
    @(negedge clk);
    bout = 1'h0;
    // brownout again in the first stretch cycle: sequence must restart
    @(negedge clk);
    bout = 1'h1;
    @(negedge clk);
    bout = 1'h0;
    wait_rst(1'h1);
    chk(cause, 5'h01, "bout cause");
    chk(eff.ram_unreliable, 5'h1, "bout ram");
    chk(eff, 5'h0a, "bout effect");
    $display("test brownout done");
  endtask

  // 40 ns pulse is refused, 120 ns pulse is taken; stray wake-up ignored when running
  task automatic t_pin();
    i_ext_rst_model.pin_reset(1, 3'h4);
    wake = 1'h1;
    repeat (8) @(negedge clk);
    wake = 1'h0;
    chk(sys_n, 5'h1, "short pulse");
    i_ext_rst_model.pin_reset(3, 3'h0);
    wait_rst(1'h0);
    wait_rst(1'h1);
    chk(cause, 5'h08, "pin cause");
    chk(boot, BOOT_LOADER, "pin boot");
    chk(eff.ram_unreliable, 5'h0, "pin ram");
    chk(eff, 5'h03, "pin effect");
    $display("test pin done");
  endtask

  // enter power-down, then leave it by pin (wake=0) or by wake-up (wake=1)
  task automatic t_pd(input logic by_wake);
    @(negedge clk);
    pd_req = 1'h1;
    repeat (4) @(negedge clk);
    chk(pd, 5'h1, "pd entered");
    chk(main_en, 5'h0, "main reg pd");
    chk(lp_en, 5'h1, "lp reg pd");
    pd_req = 1'h0;
    wake = by_wake;
    if (!by_wake)
      i_ext_rst_model.pin_reset(3, 3'h6);
    wait_rst(1'h0);
    @(negedge clk);
    wake = 1'h0;
    wait_rst(1'h1);
    chk(cause, by_wake ? 5'h02 : 5'h08, "pd exit cause");
    chk(boot, BOOT_JTAG, "pd exit boot");
    chk(eff.ram_unreliable, 5'h0, "pd exit ram");
    chk(main_en, 5'h1, "main reg back");
    chk(pd, 5'h0, "pd left");
    $display("test power_down done");
  endtask

  // main sequence; each wait is bounded inside wait_rst
  initial
  begin
    t_power_on(BOOT_DEBUG);
    t_watchdog();
    t_brownout();
    t_pin();
    t_pd(1'h0);
    t_pd(1'h1);
    t_power_on(BOOT_JTAG);
    give_verdict();
  end
endmodule // tb_reset_control_unit
`default_nettype wire
